//--- rtl/tco_defs.svh
// Register offsets, field positions, reset values and mode codes
// Assumes byte addressing on a 32-bit Avalon-MM slave port
`ifndef TCO_DEFS_SVH
`define TCO_DEFS_SVH
`define TCO_OFS_CTRL_A  5'h00
`define TCO_OFS_CTRL_C  5'h04
`define TCO_OFS_COUNT   5'h08
`define TCO_OFS_CMP_A   5'h0c
`define TCO_OFS_CMP_B   5'h10
`define TCO_OFS_CAPTURE 5'h14
`define TCO_OFS_FLAGS   5'h18
`define TCO_OFS_PORT    5'h1c
`define TCO_FRC_A_BIT   0
`define TCO_FRC_B_BIT   1
`define TCO_RST_BYTE    8'h00
`define TCO_RST_WORD    16'h0000
`define TCO_MAX         16'hffff
`define TCO_WGM_NORMAL  4'h0
`define TCO_WGM_CTC_CMP 4'h4
`define TCO_WGM_CTC_CAP 4'hc
`define TCO_COM_NONE    2'h0
`define TCO_COM_TOGGLE  2'h1
`define TCO_COM_CLEAR   2'h2
`define TCO_COM_SET     2'h3
`endif

//--- rtl/tco_pkg.sv
// Types shared by the compare output timer
// Assumes the offsets and codes in tco_defs.svh
package tco_pkg;
  // Control byte: mode select on top, output modes below
  typedef struct packed {
    logic [3:0] waveform_mode_select;
    logic [1:0] compare_b_output_mode;
    logic [1:0] compare_a_output_mode;
  } tco_ctrl_t;
  // General-purpose port value and direction bits
  typedef struct packed {
    logic dir_b;
    logic val_b;
    logic dir_a;
    logic val_a;
  } tco_port_t;
  // Sticky event flags
  typedef struct packed {
    logic capture_flag;
    logic compare_b_flag;
    logic compare_a_flag;
    logic overflow_flag;
  } tco_flags_t;
  // Bus handshake phase
  typedef enum logic {TCO_BUS_IDLE, TCO_BUS_ACK} tco_bus_t;
endpackage : tco_pkg

//--- rtl/tco_timer_compare.sv
// 16-bit timer with compare-match outputs, Normal and clear modes
// Assumes timer_tick is a one-cycle enable on sys_clk (prescaler
// lives outside) and a master that holds requests until waitrequest
// drops.
// What this block does
// - A count write blocks all compare matches during the next tick.
// - Output state registers survive any waveform mode change.
// - Output mode is unbuffered; it acts from the next match on.
// - Output state registers clear to zero on system reset.
// - Nonzero output mode replaces port value; direction stays with port.
// - Waveform reaches pin only when direction is output, in any mode.
// - Output mode never influences the capture path.
// - Output mode zero leaves the output state unchanged at a match.
// - In non-PWM modes a force strobe applies the action at once.
// - Counting depends only on waveform mode, never on output mode.
// - Non-PWM output modes select set, clear or toggle at a match.
// - Normal mode counts up only, wrapping from ffff to zero.
// - Normal mode sets overflow as count becomes zero; set only.
// - Normal mode accepts count writes at any time.
// - Mode 4 clears on compare A match; mode c on capture match.
// - Reaching top sets compare A flag or capture flag accordingly.
// - Top is unbuffered; top below count runs to ffff and wraps.
// - Toggle mode in clear modes toggles channel A on every match.
// - Clear modes set overflow when count passes ffff to zero.
// - A forced compare sets no flag and leaves the counter alone.
// - A match sets its flag next tick; writing one clears it.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "tco_defs.svh"
module tco_timer_compare (
  input  wire logic        sys_clk,           // System clock, 100 MHz
  input  wire logic        sys_rst,           // Sync reset, active high
  input  wire logic        clk_en,            // Freezes all state when low
  input  wire logic        timer_tick,        // Timer clock enable pulse
  input  wire logic [4:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read request
  input  wire logic        avs_write,         // Write request
  input  wire logic [31:0] avs_writedata,     // Write data
  input  wire logic [3:0]  avs_byteenable,    // Byte lanes
  output logic      [31:0] avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall, active high
  output logic             pin_a_out,         // Channel A pin level
  output logic             pin_a_oe,          // Channel A pin drive
  output logic             pin_b_out,         // Channel B pin level
  output logic             pin_b_oe           // Channel B pin drive
);
  tco_pkg::tco_ctrl_t  timer_control_a_reg;
  tco_pkg::tco_port_t  port_reg;
  tco_pkg::tco_flags_t timer_flag_register_reg;
  tco_pkg::tco_flags_t flag_set;
  tco_pkg::tco_flags_t flag_clr;
  tco_pkg::tco_bus_t   bus_reg;
  logic [15:0] count_value_reg;
  logic [15:0] count_value_next;
  logic [15:0] compare_a_value_reg;
  logic [15:0] compare_b_value_reg;
  logic [15:0] capture_value_reg;
  logic        compare_a_output_state_reg;
  logic        compare_b_output_state_reg;
  logic        block_reg;
  logic [31:0] rdata_next;
  logic        acc;
  logic        wr;
  logic        tick;
  logic        non_pwm;
  logic        hit_a;
  logic        hit_b;
  logic        hit_cap;
  logic        clear_top;
  logic        frc_a;
  logic        frc_b;
  logic        cnt_wr;
  logic [3:0]  wgm;
  logic [1:0]  com_a;
  logic [1:0]  com_b;

  // Output action for a match or a force
  function automatic logic oc_act(input logic [1:0] com,
                                  input logic       cur);
    unique case (com)
      `TCO_COM_TOGGLE: oc_act = ~cur;
      `TCO_COM_CLEAR:  oc_act = 1'b0;
      `TCO_COM_SET:    oc_act = 1'b1;
      `TCO_COM_NONE:   oc_act = cur;
    endcase
  endfunction : oc_act

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8],
               be[0] ? wd[7:0]  : old[7:0]};
  endfunction : merge16

  // Write strobe to one register offset
  function automatic logic wr_to(input logic       w,
                                 input logic [4:0] a,
                                 input logic [4:0] ofs);
    wr_to = w && (a == ofs);
  endfunction : wr_to

  assign wgm   = timer_control_a_reg.waveform_mode_select;
  assign com_a = timer_control_a_reg.compare_a_output_mode;
  assign com_b = timer_control_a_reg.compare_b_output_mode;

  // Bus acceptance: only while the one-cycle answer stands
  assign acc    = (bus_reg == tco_pkg::TCO_BUS_ACK) &&
                  (avs_read || avs_write);
  assign wr     = acc && avs_write;
  assign tick   = clk_en && timer_tick;
  assign cnt_wr = clk_en && wr_to(wr, avs_address, `TCO_OFS_COUNT);

  // Non-PWM means Normal or either clear mode
  // Limitation: PWM modes are not built; they count like Normal
  assign non_pwm = (wgm == `TCO_WGM_NORMAL) ||
                   (wgm == `TCO_WGM_CTC_CMP) ||
                   (wgm == `TCO_WGM_CTC_CAP);

  // matches masked after a count write
  assign hit_a   = tick && !block_reg &&
                   (count_value_reg == compare_a_value_reg);
  assign hit_b   = tick && !block_reg &&
                   (count_value_reg == compare_b_value_reg);
  // capture match never looks at output modes
  assign hit_cap = tick && !block_reg &&
                   (wgm == `TCO_WGM_CTC_CAP) &&
                   (count_value_reg == capture_value_reg);

  // top clear from compare A or capture
  assign clear_top = ((wgm == `TCO_WGM_CTC_CMP) && hit_a) || hit_cap;

  // force strobes, honoured in non-PWM modes only
  assign frc_a = clk_en && non_pwm && avs_byteenable[0] &&
                 wr_to(wr, avs_address, `TCO_OFS_CTRL_C) &&
                 avs_writedata[`TCO_FRC_A_BIT];
  assign frc_b = clk_en && non_pwm && avs_byteenable[0] &&
                 wr_to(wr, avs_address, `TCO_OFS_CTRL_C) &&
                 avs_writedata[`TCO_FRC_B_BIT];

  // plain increment wraps ffff to zero
  // top below count simply keeps counting through the wrap
  always_comb begin
    if (clear_top) begin
      count_value_next = `TCO_RST_WORD;
    end else begin
      count_value_next = count_value_reg + 16'h0001;
    end
  end

  // Bus handshake; waitrequest drops for one cycle per request
  // The idle turn after each answer stops a held request counting twice
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bus_reg         <= tco_pkg::TCO_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else if (clk_en) begin
      if (bus_reg == tco_pkg::TCO_BUS_IDLE &&
          (avs_read || avs_write)) begin
        bus_reg         <= tco_pkg::TCO_BUS_ACK;
        avs_waitrequest <= 1'b0;
      end else begin
        bus_reg         <= tco_pkg::TCO_BUS_IDLE;
        avs_waitrequest <= 1'b1;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address)
      `TCO_OFS_CTRL_A:  rdata_next[7:0] = timer_control_a_reg;
      `TCO_OFS_COUNT:   rdata_next[15:0] = count_value_reg;
      `TCO_OFS_CMP_A:   rdata_next[15:0] = compare_a_value_reg;
      `TCO_OFS_CMP_B:   rdata_next[15:0] = compare_b_value_reg;
      `TCO_OFS_CAPTURE: rdata_next[15:0] = capture_value_reg;
      `TCO_OFS_FLAGS:   rdata_next[5:0] =
                          {compare_b_output_state_reg,
                           compare_a_output_state_reg,
                           timer_flag_register_reg};
      `TCO_OFS_PORT:    rdata_next[3:0] = port_reg;
      default:          rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data loaded as the answer is raised, so it stands with it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && bus_reg == tco_pkg::TCO_BUS_IDLE &&
                 avs_read) begin
      avs_readdata <= rdata_next;
    end
  end

  // Control, port and compare registers
  // mode changes never touch the output states
  // output mode takes effect directly, no shadow copy
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_control_a_reg <= `TCO_RST_BYTE;
      port_reg            <= 4'h0;
      compare_a_value_reg <= `TCO_RST_WORD;
      compare_b_value_reg <= `TCO_RST_WORD;
      capture_value_reg   <= `TCO_RST_WORD;
    end else if (clk_en) begin
      if (wr_to(wr, avs_address, `TCO_OFS_CTRL_A) && avs_byteenable[0])
        timer_control_a_reg <= avs_writedata[7:0];
      if (wr_to(wr, avs_address, `TCO_OFS_PORT) && avs_byteenable[0])
        port_reg <= avs_writedata[3:0];
      if (wr_to(wr, avs_address, `TCO_OFS_CMP_A))
        compare_a_value_reg <= merge16(compare_a_value_reg,
                                       avs_writedata, avs_byteenable);
      if (wr_to(wr, avs_address, `TCO_OFS_CMP_B))
        compare_b_value_reg <= merge16(compare_b_value_reg,
                                       avs_writedata, avs_byteenable);
      if (wr_to(wr, avs_address, `TCO_OFS_CAPTURE))
        capture_value_reg <= merge16(capture_value_reg,
                                     avs_writedata, avs_byteenable);
    end
  end

  // count write wins over a tick in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      count_value_reg <= `TCO_RST_WORD;
    end else if (cnt_wr) begin
      count_value_reg <= merge16(count_value_reg, avs_writedata,
                                 avs_byteenable);
    end else if (tick) begin
      count_value_reg <= count_value_next;
    end
  end

  // block armed by a count write, spent by the next tick
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      block_reg <= 1'b0;
    end else if (cnt_wr) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // mode zero keeps the state; via oc_act
  // forcing only moves the state, nothing else
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      compare_a_output_state_reg <= 1'b0;
      compare_b_output_state_reg <= 1'b0;
    end else if (clk_en) begin
      if (hit_a || frc_a)
        compare_a_output_state_reg <= oc_act(com_a,
                                      compare_a_output_state_reg);
      if (hit_b || frc_b)
        compare_b_output_state_reg <= oc_act(com_b,
                                      compare_b_output_state_reg);
    end
  end

  // overflow as count goes ffff to zero; same in clear modes
  // top match raises compare A or capture flag
  // flags set at the tick after equality is seen
  always_comb begin
    flag_set.overflow_flag  = tick && (count_value_reg == `TCO_MAX);
    flag_set.compare_a_flag = hit_a;
    flag_set.compare_b_flag = hit_b;
    flag_set.capture_flag   = hit_cap;
    flag_clr = 4'h0;
    if (clk_en && wr_to(wr, avs_address, `TCO_OFS_FLAGS) &&
        avs_byteenable[0])
      flag_clr = avs_writedata[3:0];
  end

  // write one clears; a set in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      timer_flag_register_reg <= 4'h0;
    end else if (clk_en) begin
      timer_flag_register_reg <= (timer_flag_register_reg & ~flag_clr)
                                 | flag_set;
    end
  end

  // nonzero mode selects the waveform over the port value
  // direction bit alone enables the drive, in every mode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_a_out <= 1'b0;
      pin_a_oe  <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe  <= 1'b0;
    end else if (clk_en) begin
      pin_a_out <= (com_a != `TCO_COM_NONE) ?
                   compare_a_output_state_reg : port_reg.val_a;
      pin_a_oe  <= port_reg.dir_a;
      pin_b_out <= (com_b != `TCO_COM_NONE) ?
                   compare_b_output_state_reg : port_reg.val_b;
      pin_b_oe  <= port_reg.dir_b;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Count write followed by the tick it blocks
  sequence s_cnt_write;
    cnt_wr;
  endsequence
  sequence s_blocked_tick;
    block_reg && tick;
  endsequence

  a_write_blocks_match: assert property (
    s_blocked_tick && !frc_a && !frc_b |=>
      $stable(compare_a_output_state_reg) &&
      $stable(compare_b_output_state_reg))
    else $error("compare match seen while blocked");
  a_block_spent: assert property (
    s_blocked_tick && !cnt_wr |=> !block_reg)
    else $error("block outlived its tick");
  a_block_armed: assert property (
    s_cnt_write |=> block_reg)
    else $error("count write did not arm block");
  a_state_reset: assert property (disable iff (1'b0)
    sys_rst |=> !compare_a_output_state_reg &&
                !compare_b_output_state_reg)
    else $error("output state not cleared by reset");
  a_mode_zero_hold: assert property (
    hit_a && com_a == `TCO_COM_NONE |=>
      compare_a_output_state_reg == $past(compare_a_output_state_reg))
    else $error("output state moved with mode zero");
  a_toggle_match: assert property (
    hit_a && com_a == `TCO_COM_TOGGLE |=>
      compare_a_output_state_reg != $past(compare_a_output_state_reg))
    else $error("toggle mode did not toggle");
  a_force_no_flag: assert property (
    frc_a && !hit_a && !timer_flag_register_reg.compare_a_flag |=>
      !timer_flag_register_reg.compare_a_flag)
    else $error("force raised the compare flag");
  a_normal_wrap: assert property (
    tick && !cnt_wr && wgm == `TCO_WGM_NORMAL &&
    count_value_reg == `TCO_MAX |=>
      count_value_reg == `TCO_RST_WORD &&
      timer_flag_register_reg.overflow_flag)
    else $error("normal wrap or overflow wrong");
  a_ctc_top_clear: assert property (
    hit_a && !cnt_wr && wgm == `TCO_WGM_CTC_CMP |=>
      count_value_reg == `TCO_RST_WORD &&
      timer_flag_register_reg.compare_a_flag)
    else $error("clear on compare A failed");
  a_flag_set_wins: assert property (
    hit_b && flag_clr.compare_b_flag |=>
      timer_flag_register_reg.compare_b_flag)
    else $error("flag clear beat a set");
  a_pin_override: assert property (
    clk_en && com_a != `TCO_COM_NONE ##1 1'b1 |->
      pin_a_out == $past(compare_a_output_state_reg) &&
      pin_a_oe == $past(port_reg.dir_a))
    else $error("pin override wrong");
  // State moves only on a match or a force, never on a mode write
  a_state_hold: assert property (
    !hit_a && !frc_a |=> $stable(compare_a_output_state_reg))
    else $error("output state moved without a match");
  // Forcing leaves the count where it was
  a_force_count_kept: assert property (
    frc_a && !tick && !cnt_wr |=> $stable(count_value_reg))
    else $error("force disturbed the counter");
endmodule : tco_timer_compare

//--- dv/tco_timer_compare_tb.sv
// Self-checking bench for the compare output timer
// Assumes the design defines header and one 100 MHz sys_clk domain
`timescale 1ns/1ns
`include "tco_defs.svh"
module timer_compare_output_ctc_tb_top;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] cap;
    logic [15:0] cnt;
    logic [3:0]  ticks;
    logic [15:0] exp_cnt;
    logic [5:0]  exp_flg;
  } tco_row_t;

  logic        sys_clk;
  logic        sys_rst;
  logic        clk_en;
  logic        timer_tick;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pin_a_out;
  logic        pin_a_oe;
  logic        pin_b_out;
  logic        pin_b_oe;
  logic [31:0] q;
  int          error_cnt;
  int          n_compared;
  int          cyc = 0;

  // Flags read as {state B, state A, capture, cmp B, cmp A, overflow}
  // row 6 writes count equal to compare A to show the lost match
  tco_row_t rows [8] = '{
    '{8'h00, 16'h0100, 16'h1234, 16'h0, 16'hfffe, 4'h3, 16'h0001, 6'h01},
    '{8'h41, 16'h0002, 16'h1234, 16'h0, 16'h0000, 4'h3, 16'h0000, 6'h12},
    '{8'hc2, 16'h0005, 16'h1234, 16'h3, 16'h0000, 4'h5, 16'h0001, 6'h18},
    '{8'h02, 16'h0004, 16'h1234, 16'h0, 16'h0003, 4'h2, 16'h0005, 6'h02},
    '{8'h0f, 16'h0007, 16'h0007, 16'h0, 16'h0006, 4'h2, 16'h0008, 6'h36},
    '{8'h40, 16'h0001, 16'h1234, 16'h0, 16'h0000, 4'h2, 16'h0000, 6'h32},
    '{8'h01, 16'h0009, 16'h1234, 16'h0, 16'h0009, 4'h1, 16'h000a, 6'h30},
    '{8'h40, 16'h0002, 16'h1234, 16'h0, 16'hfffe, 4'h5, 16'h0000, 6'h33}
  };

  tco_timer_compare dut (
    .sys_clk         (sys_clk),
    .sys_rst         (sys_rst),
    .clk_en          (clk_en),
    .timer_tick      (timer_tick),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .pin_a_out       (pin_a_out),
    .pin_a_oe        (pin_a_oe),
    .pin_b_out       (pin_b_out),
    .pin_b_oe        (pin_b_oe)
  );

  // Free-running system clock
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] rq);
    @(posedge sys_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= (a >= 5'h08 && a <= 5'h14) ? 4'h3 : 4'h1;
    // No wait limit here: only the hang guard ends a stuck transfer
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Timer clock pulses, one cycle high then one low
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      timer_tick <= 1'b1;
      @(posedge sys_clk);
      timer_tick <= 1'b0;
    end
  endtask : tick

  // Port and control written, pins settle one edge later
  task automatic pins(input logic [7:0] port, input logic [7:0] ctrl,
                      input logic [3:0] exp);
    bus(1'b1, `TCO_OFS_CTRL_A, {24'h0, ctrl}, q);
    bus(1'b1, `TCO_OFS_PORT, {24'h0, port}, q);
    repeat (2) @(posedge sys_clk);
    chk({28'h0, pin_b_oe, pin_b_out, pin_a_oe, pin_a_out}, {28'h0, exp},
        "pins");
  endtask : pins

  // Hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  initial begin
    sys_rst = 1'b1; clk_en = 1'b1; timer_tick = 1'b0;
    avs_address = 5'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; avs_byteenable = 4'h0;
    error_cnt = 0; n_compared = 0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    bus(1'b0, `TCO_OFS_FLAGS, 32'h0, q);
    chk({26'h0, q[5:0]}, 32'h0, "reset flags");
    foreach (rows[i]) begin
      bus(1'b1, `TCO_OFS_CTRL_A, {24'h0, rows[i].ctrl}, q);
      bus(1'b1, `TCO_OFS_CMP_A, {16'h0, rows[i].cmp_a}, q);
      bus(1'b1, `TCO_OFS_CMP_B, {16'h0, rows[i].cmp_b}, q);
      bus(1'b1, `TCO_OFS_CAPTURE, {16'h0, rows[i].cap}, q);
      bus(1'b1, `TCO_OFS_COUNT, {16'h0, rows[i].cnt}, q);
      bus(1'b1, `TCO_OFS_FLAGS, 32'h0f, q);
      tick(rows[i].ticks);
      bus(1'b0, `TCO_OFS_COUNT, 32'h0, q);
      chk({16'h0, q[15:0]}, {16'h0, rows[i].exp_cnt}, "count");
      bus(1'b0, `TCO_OFS_FLAGS, 32'h0, q);
      chk({26'h0, q[5:0]}, {26'h0, rows[i].exp_flg}, "flags");
    end
    // force toggles A, no flag, counter untouched
    // state set by a force before any pin is driven
    bus(1'b1, `TCO_OFS_CTRL_A, 32'h01, q);
    bus(1'b1, `TCO_OFS_COUNT, 32'h0040, q);
    bus(1'b1, `TCO_OFS_FLAGS, 32'h0f, q);
    bus(1'b1, `TCO_OFS_CTRL_C, 32'h01, q);
    bus(1'b0, `TCO_OFS_FLAGS, 32'h0, q);
    chk({26'h0, q[5:0]}, 32'h20, "forced flags");
    bus(1'b0, `TCO_OFS_COUNT, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h0040, "forced count");
    bus(1'b0, `TCO_OFS_CTRL_C, 32'h0, q);
    chk(q, 32'h0, "strobe readback");
    // override by output mode, direction from port
    pins(8'h0b, 8'h01, 4'b1010);
    pins(8'h0b, 8'h00, 4'b1011);
    pins(8'h0b, 8'h04, 4'b1111);
    pins(8'h0b, 8'hc5, 4'b1110);
    bus(1'b1, `TCO_OFS_PORT, 32'h00, q);
    repeat (2) @(posedge sys_clk);
    chk({30'h0, pin_b_oe, pin_a_oe}, 32'h0, "pin drive");
    // frozen clock enable holds count, then resumes
    bus(1'b1, `TCO_OFS_CTRL_A, 32'h00, q);
    bus(1'b1, `TCO_OFS_COUNT, 32'h0100, q);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    tick(3);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    tick(1);
    bus(1'b0, `TCO_OFS_COUNT, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h0101, "gated count");
    // flag clear and compare B match on one edge: the set wins
    bus(1'b1, `TCO_OFS_CMP_B, 32'h0202, q);
    bus(1'b1, `TCO_OFS_COUNT, 32'h0200, q);
    timer_tick <= 1'b1;
    bus(1'b1, `TCO_OFS_FLAGS, 32'h0f, q);
    timer_tick <= 1'b0;
    bus(1'b0, `TCO_OFS_FLAGS, 32'h0, q);
    chk({26'h0, q[5:0]}, 32'h24, "set beats clear");
    bus(1'b0, `TCO_OFS_COUNT, 32'h0, q);
    chk({16'h0, q[15:0]}, 32'h0203, "ticked count");
    // reset in mid-run clears states and pins
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    chk({29'h0, avs_waitrequest, pin_b_oe, pin_a_oe}, 32'h4,
        "reset drive");
    bus(1'b0, `TCO_OFS_FLAGS, 32'h0, q);
    chk({26'h0, q[5:0]}, 32'h0, "rerun flags");
    end_sim();
  end
endmodule : timer_compare_output_ctc_tb_top
